// ===== logic/mmf_cmd_check.sv
// Command word field decode and content checks.
// Assumes a command word that has already passed word validation.
`timescale 1ns/100ps
`include "mmf_regs.svh"

module mmf_cmd_check (
  input wire logic [15:0] cmd_i, // Command word
  output logic [4:0] addr_o, // Terminal address
  output logic tx_o, // Transmit/receive bit
  output logic mode_o, // Subaddress marks a mode command
  output logic [5:0] exp_o, // Expected data words
  output logic fault_o, // Any content fault
  output logic hard_o // Content fault that counts as error
);

  logic [4:0] sa;
  logic [4:0] wc;
  logic bcast;
  logic bc_tx_nonmode;
  logic rx_undef;
  logic bc_bad_mode;

  // Field split
  assign addr_o = cmd_i[15:11];
  assign tx_o = cmd_i[10];
  assign sa = cmd_i[9:5];
  assign wc = cmd_i[4:0];
  assign mode_o = (sa == 5'h00) || (sa == 5'h1F);
  assign bcast = (addr_o == `MMF_BCAST_ADDR);

  // Mode codes 16 and up carry one data word; zero word count means 32
  assign exp_o = mode_o ? {5'h00, wc[4]} :
                 (wc == 5'h00) ? 6'h20 : {1'b0, wc};

  // Content checks
  assign bc_tx_nonmode = bcast && tx_o && !mode_o;
  assign rx_undef = !tx_o && mode_o && !wc[4];
  assign bc_bad_mode = bcast && tx_o && mode_o &&
    ((wc == 5'h00) || (wc == 5'h02) || (wc == 5'h10) ||
     (wc == 5'h12) || (wc == 5'h13));
  assign fault_o = bc_tx_nonmode || rx_undef || bc_bad_mode;
  assign hard_o = bc_tx_nonmode || bc_bad_mode;

endmodule // mmf_cmd_check

// ===== logic/mmf_msg_flags.sv
// Monitor message flag classifier with an APB register slave.
// Assumes an upstream decoder and message sequencer on clk_sys_i that
// mark each word's role and a buffer manager that reports rollover.
//
// What this block does
// - Set bit 7 when the message's storage wrapped to buffer base.
// - Set bit 6 when any status bit is set in a status response.
// - Set bit 5 when data word count differs from command word count.
// - Keep bit 5 clear on busy status or transmit command timeout.
// - Set bit 4 on command/status with data sync, or data with other.
// - Set bit 3 on Manchester, bit count or parity error in a word.
// - RT-RT: set bit 2 on response gap under 4us when enabled.
// - RT-RT: set bit 2 when either terminal's status word is invalid.
// - RT-RT: set bit 2 when status address differs from its command.
// - RT-RT: set bit 1 when second command is a receive command.
// - RT-RT: set bit 1 when second command subaddress is mode.
// - RT-RT: set bit 1 when both commands name the same terminal.
// - RT-RT: set bit 1 when second command has a sync error.
// - Set bit 0 for broadcast transmit with non-mode subaddress.
// - Set bit 0 for receive mode code in range 0 to 15.
// - Set bit 0 for broadcast transmit mode code 0,2,16,18,19.
// - Set bit 12 when any of bits 9,5,4,3,2,1,0 is set.
// - Bit 12 ignores mode subaddress, same address, undefined rx mode.
// - Set bit 8 after an error-free message, clear it otherwise.
// - Set bit 9 when an expected status misses the set interval.
`timescale 1ns/100ps
`include "mmf_regs.svh"

module mmf_msg_flags
  import mmf_pkg::*;
#(
  parameter int unsigned TO0_CYC = `MMF_TO0_US * `MMF_CLK_MHZ,
  parameter int unsigned TO1_CYC = `MMF_TO1_US * `MMF_CLK_MHZ,
  parameter int unsigned TO2_CYC = `MMF_TO2_US * `MMF_CLK_MHZ,
  parameter int unsigned TO3_CYC = `MMF_TO3_US * `MMF_CLK_MHZ
) (
  input wire logic clk_sys_i, // System clock, 100 MHz
  input wire logic resetn_i, // Async reset, active low
  input wire logic word_valid_i, // Word decoded, at mid-parity
  input wire logic [15:0] word_data_i, // Decoded word bits
  input wire mmf_role_t word_role_i, // Role of the word
  input wire logic word_cmd_sync_i, // Word had command/status sync
  input wire logic word_bad_i, // Manchester, bit count or parity
  input wire logic sync_seen_i, // Mid-sync of a word, pulse
  input wire logic resp_wait_i, // A status response is awaited
  input wire logic rollover_i, // Storage pointer wrapped, pulse
  input wire logic msg_end_i, // Message complete, pulse
  output logic rec_valid_o, // Record word strobe
  output logic [15:0] rec_word_o, // Message information word
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr // APB error
);

  // Message state and per-message accumulators
  mmf_state_t state_r;
  mmf_state_t state_nxt;
  logic roll_r, roll_nxt;
  logic sfs_r, sfs_nxt;
  logic sync_r, sync_nxt;
  logic inv_r, inv_nxt;
  logic rt_pair_gap_sync_addr_fault_r, rt_pair_gap_sync_addr_fault_nxt;
  logic cw2h_r, cw2h_nxt;
  logic cw2s_r, cw2s_nxt;
  logic ccfh_r, ccfh_nxt;
  logic ccfs_r, ccfs_nxt;
  logic tmo_r, tmo_nxt;
  logic busy_r, busy_nxt;
  logic rtrt_r, rtrt_nxt;
  logic txc_r, txc_nxt;
  logic stat2_r, stat2_nxt;
  logic [4:0] addr1_r, addr1_nxt;
  logic [4:0] addr2_r, addr2_nxt;
  logic [5:0] dcnt_r, dcnt_nxt;
  logic [5:0] ecnt_r, ecnt_nxt;
  logic [15:0] gap_cnt_r;
  logic gap_short_r;
  logic [15:0] cfg_r;
  logic [31:0] prdata_r;

  // Word qualifiers
  logic is_c1, is_c2, is_dat, is_st, start;
  logic in_msg;
  logic cmd_word;
  logic [4:0] c_addr;
  logic c_tx, c_mode, c_fault, c_hard;
  logic [5:0] c_exp;

  // One decoder serves both command slots; only one arrives per cycle
  assign is_c1 = word_valid_i && (word_role_i == ROLE_CMD1);
  assign is_c2 = word_valid_i && (word_role_i == ROLE_CMD2);
  assign is_dat = word_valid_i && (word_role_i == ROLE_DATA);
  assign is_st = word_valid_i && (word_role_i == ROLE_STAT);
  assign start = is_c1;
  assign in_msg = (state_r == ST_MSG) || start;
  assign cmd_word = is_c1 || is_c2;

  mmf_cmd_check u_cmd (
    .cmd_i (word_data_i),
    .addr_o (c_addr),
    .tx_o (c_tx),
    .mode_o (c_mode),
    .exp_o (c_exp),
    .fault_o (c_fault),
    .hard_o (c_hard)
  );

  // Base values: a first command word drops last message's flags
  logic b_roll, b_sfs, b_sync, b_inv, b_rt_pair_gap_sync_addr_fault, b_cw2h, b_cw2s;
  logic b_ccfh, b_ccfs, b_tmo, b_busy;
  logic [5:0] b_dcnt;
  assign b_roll = !start && roll_r;
  assign b_sfs = !start && sfs_r;
  assign b_sync = !start && sync_r;
  assign b_inv = !start && inv_r;
  assign b_rt_pair_gap_sync_addr_fault = !start && rt_pair_gap_sync_addr_fault_r;
  assign b_cw2h = !start && cw2h_r;
  assign b_cw2s = !start && cw2s_r;
  assign b_ccfh = !start && ccfh_r;
  assign b_ccfs = !start && ccfs_r;
  assign b_tmo = !start && tmo_r;
  assign b_busy = !start && busy_r;
  assign b_dcnt = start ? 6'h00 : dcnt_r;

  // Status word checks; in RT-RT the transmitter answers first
  logic st_bad, st_addr_bad, st_gap_bad;
  logic [4:0] st_exp_addr;
  assign st_exp_addr = (rtrt_r && !stat2_r) ? addr2_r : addr1_r;
  assign st_bad = word_bad_i || !word_cmd_sync_i;
  assign st_addr_bad = word_data_i[15:11] != st_exp_addr;
  assign st_gap_bad = cfg_r[`MMF_CFG_GAP_EN] && gap_short_r;

  // Sync type: commands and status need command sync, data needs data
  logic sync_ev;
  assign sync_ev = ((cmd_word || is_st) && !word_cmd_sync_i) ||
                   (is_dat && word_cmd_sync_i);

  // Second command checks, split by whether they count as error
  logic cw2_hard_ev, cw2_soft_ev;
  assign cw2_hard_ev = is_c2 && (!c_tx || !word_cmd_sync_i);
  assign cw2_soft_ev = is_c2 && (c_mode || (c_addr == addr1_r));

  // Response timeout limit chosen by configuration
  logic [15:0] to_lim;
  logic tmo_ev;
  logic [1:0] to_sel;
  assign to_sel = cfg_r[`MMF_CFG_TO_HI:`MMF_CFG_TO_LO];
  assign to_lim = (to_sel == 2'd0) ? TO0_CYC[15:0] :
                  (to_sel == 2'd1) ? TO1_CYC[15:0] :
                  (to_sel == 2'd2) ? TO2_CYC[15:0] : TO3_CYC[15:0];
  assign tmo_ev = (state_r == ST_MSG) && resp_wait_i &&
                  (gap_cnt_r >= to_lim);

  // Next values of the accumulators
  assign roll_nxt = in_msg && (b_roll || rollover_i);
  assign sfs_nxt = b_sfs || (is_st && (|word_data_i[10:0]));
  assign busy_nxt = b_busy || (is_st && word_data_i[`MMF_ST_BUSY]);
  assign sync_nxt = b_sync || sync_ev;
  assign inv_nxt = b_inv || (word_valid_i && word_bad_i);
  assign rt_pair_gap_sync_addr_fault_nxt = b_rt_pair_gap_sync_addr_fault || (is_st && rtrt_r &&
    (st_gap_bad || st_bad || st_addr_bad));
  assign cw2h_nxt = b_cw2h || cw2_hard_ev;
  assign cw2s_nxt = b_cw2s || cw2_soft_ev;
  assign ccfh_nxt = b_ccfh || (cmd_word && c_hard);
  assign ccfs_nxt = b_ccfs || (cmd_word && c_fault);
  assign tmo_nxt = b_tmo || tmo_ev;
  assign dcnt_nxt = is_dat ? b_dcnt + 6'h01 : b_dcnt;
  assign rtrt_nxt = start ? 1'b0 : (rtrt_r || is_c2);
  assign stat2_nxt = start ? 1'b0 : (stat2_r || is_st);
  assign addr1_nxt = is_c1 ? c_addr : addr1_r;
  assign addr2_nxt = is_c2 ? c_addr : addr2_r;
  // RT-RT length follows the receive command; transmitter is the second
  assign ecnt_nxt = is_c1 ? c_exp : ecnt_r;
  assign txc_nxt = is_c1 ? c_tx : (is_c2 ? 1'b1 : txc_r);

  // Record word assembly from the values that include this cycle
  logic wcm, any_f, good;
  logic [15:0] rec_nxt;
  assign wcm = (dcnt_nxt != ecnt_nxt) && !busy_nxt &&
               !(tmo_nxt && txc_nxt);
  assign any_f = tmo_nxt || wcm || sync_nxt || inv_nxt || rt_pair_gap_sync_addr_fault_nxt ||
                 cw2h_nxt || ccfh_nxt;
  assign good = !any_f;
  always_comb
  begin
    rec_nxt = 16'h0000;
    rec_nxt[`MMF_B_ANY] = any_f;
    rec_nxt[`MMF_B_TMO] = tmo_nxt;
    rec_nxt[`MMF_B_GOOD] = good;
    rec_nxt[`MMF_B_ROLL] = roll_nxt;
    rec_nxt[`MMF_B_SFS] = sfs_nxt;
    rec_nxt[`MMF_B_WCM] = wcm;
    rec_nxt[`MMF_B_SYNC] = sync_nxt;
    rec_nxt[`MMF_B_INV] = inv_nxt;
    rec_nxt[`MMF_B_RT_PAIR_GAP_SYNC_ADDR_FAULT] = rt_pair_gap_sync_addr_fault_nxt;
    rec_nxt[`MMF_B_CW2] = cw2h_nxt || cw2s_nxt;
    rec_nxt[`MMF_B_CCF] = ccfs_nxt;
  end

  // Message state: opened by a first command, closed by message end
  logic rec_fire;
  assign rec_fire = msg_end_i && in_msg;
  always_comb
  begin
    case (state_r)
      ST_IDLE: state_nxt = start ? ST_MSG : ST_IDLE;
      ST_MSG: state_nxt = (msg_end_i && !start) ? ST_IDLE : ST_MSG;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Flag accumulators
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      {roll_r, sfs_r, sync_r, inv_r, rt_pair_gap_sync_addr_fault_r, cw2h_r} <= 6'h00;
      {cw2s_r, ccfh_r, ccfs_r, tmo_r, busy_r} <= 5'h00;
      {rtrt_r, txc_r, stat2_r} <= 3'h0;
    end
    else
    begin
      {roll_r, sfs_r, sync_r, inv_r, rt_pair_gap_sync_addr_fault_r, cw2h_r} <=
        {roll_nxt, sfs_nxt, sync_nxt, inv_nxt, rt_pair_gap_sync_addr_fault_nxt, cw2h_nxt};
      {cw2s_r, ccfh_r, ccfs_r, tmo_r, busy_r} <=
        {cw2s_nxt, ccfh_nxt, ccfs_nxt, tmo_nxt, busy_nxt};
      {rtrt_r, txc_r, stat2_r} <= {rtrt_nxt, txc_nxt, stat2_nxt};
    end
  end

  // Addresses and word counts of the current message
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      addr1_r <= 5'h00;
      addr2_r <= 5'h00;
      dcnt_r <= 6'h00;
      ecnt_r <= 6'h00;
    end
    else
    begin
      addr1_r <= addr1_nxt;
      addr2_r <= addr2_nxt;
      dcnt_r <= dcnt_nxt;
      ecnt_r <= ecnt_nxt;
    end
  end

  // Gap counter runs from each mid-parity; saturates so long idle
  // periods cannot wrap into a false short gap
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      gap_cnt_r <= 16'h0000;
    else if (word_valid_i)
      gap_cnt_r <= 16'h0000;
    else if (gap_cnt_r != 16'hFFFF)
      gap_cnt_r <= gap_cnt_r + 16'h0001;
  end

  // Response time is judged at the next word's mid-sync
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      gap_short_r <= 1'b0;
    else if (sync_seen_i)
      gap_short_r <= gap_cnt_r < 16'(`MMF_GAP_CYC);
  end

  // Record output, one strobe per completed message
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rec_valid_o <= 1'b0;
      rec_word_o <= 16'h0000;
    end
    else
    begin
      rec_valid_o <= rec_fire;
      if (rec_fire)
        rec_word_o <= rec_nxt;
    end
  end

  // APB decode; zero wait states, so pready is simply high
  logic setup, access, hit_cfg, hit_last, hit;
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_cfg = paddr == `MMF_CFG_OFS;
  assign hit_last = paddr == `MMF_LAST_OFS;
  assign hit = hit_cfg || hit_last;
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign prdata = prdata_r;

  // Configuration: only the gap enable and timeout select are writable
  logic [15:0] cfg_mask;
  assign cfg_mask = (16'h0001 << `MMF_CFG_GAP_EN) |
                    (16'h0001 << `MMF_CFG_TO_HI) |
                    (16'h0001 << `MMF_CFG_TO_LO);
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cfg_r <= `MMF_CFG_RST;
    else if (access && pwrite && hit_cfg)
      cfg_r <= pwdata[15:0] & cfg_mask;
  end

  // Read data latched in the setup cycle, stable through access
  logic [31:0] rd_mux;
  assign rd_mux = hit_cfg ? {16'h0000, cfg_r} :
                  hit_last ? {16'h0000, rec_word_o} : 32'h00000000;
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prdata_r <= 32'h00000000;
    else if (setup && !pwrite)
      prdata_r <= rd_mux;
  end

endmodule // mmf_msg_flags

// ===== logic/mmf_pkg.sv
// Types shared by the monitor message flag block.
// Assumes nothing of its surroundings.
package mmf_pkg;

  // Role of a word, as classified by the upstream message sequencer
  typedef enum logic [1:0] {
    ROLE_CMD1,
    ROLE_CMD2,
    ROLE_DATA,
    ROLE_STAT
  } mmf_role_t;

  typedef enum logic {
    ST_IDLE,
    ST_MSG
  } mmf_state_t;

endpackage

// ===== logic/mmf_regs.svh
// Offsets, field positions, reset values and timing counts of the
// monitor message flag block. Assumes a 100 MHz system clock.
`ifndef MMF_REGS_SVH
`define MMF_REGS_SVH

// Register byte addresses on the APB slave
`define MMF_CFG_OFS 12'h000
`define MMF_LAST_OFS 12'h004
`define MMF_CFG_RST 16'h0000

// Configuration fields
`define MMF_CFG_GAP_EN 12
`define MMF_CFG_TO_HI 15
`define MMF_CFG_TO_LO 14

// Message information word bit positions
`define MMF_B_ANY 12
`define MMF_B_TMO 9
`define MMF_B_GOOD 8
`define MMF_B_ROLL 7
`define MMF_B_SFS 6
`define MMF_B_WCM 5
`define MMF_B_SYNC 4
`define MMF_B_INV 3
`define MMF_B_RT_PAIR_GAP_SYNC_ADDR_FAULT 2
`define MMF_B_CW2 1
`define MMF_B_CCF 0

// Status word fields
`define MMF_ST_BUSY 3
`define MMF_BCAST_ADDR 5'h1F

// Timing, in the units given by each name
`define MMF_CLK_MHZ 100
`define MMF_GAP_US 4
`define MMF_GAP_CYC (`MMF_GAP_US * `MMF_CLK_MHZ)
`define MMF_TO0_US 15
`define MMF_TO1_US 20
`define MMF_TO2_US 50
`define MMF_TO3_US 130

`endif

// ===== verif/mmf_bus_model.sv
// Word stream of bus controller and terminals, as a decoder presents it.
// Driven through tasks; clk_i is the system clock of the block.
`timescale 1ns/100ps

module mmf_bus_model
  import mmf_pkg::*;
(
  input wire logic clk_i, // System clock
  output logic valid_o, // Word strobe
  output logic [15:0] data_o, // Word bits
  output mmf_role_t role_o, // Word role
  output logic csync_o, // Command/status sync
  output logic bad_o, // Invalid word
  output logic sync_o, // Mid-sync pulse
  output logic wait_o, // Response awaited
  output logic roll_o, // Buffer wrap pulse
  output logic end_o // Message end pulse
);
  // Quiet bus before reset is released
  initial
  begin
    {valid_o, csync_o, bad_o, sync_o, wait_o, roll_o, end_o} = 7'h00;
    data_o = 16'h0000;
    role_o = ROLE_DATA;
  end

  // Dead time, mid-sync, then the word; qualifiers flip once the strobe
  // drops so that a stale value can never pass for a fresh one
  task automatic w(input mmf_role_t r, input logic [15:0] v,
    input logic cs, input logic bd, input int g);
    repeat (g) @(posedge clk_i);
    sync_o <= 1'b1;
    @(posedge clk_i);
    sync_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    {valid_o, data_o, csync_o, bad_o} <= {1'b1, v, cs, bd};
    role_o <= r;
    @(posedge clk_i);
    {valid_o, data_o, csync_o, bad_o} <= {1'b0, ~v, ~cs, ~bd};
    role_o <= mmf_role_t'(~r);
  endtask

  task automatic wt(input logic v);
    @(posedge clk_i);
    wait_o <= v;
  endtask

  // Single-cycle pulses: wrap and message end
  task automatic roll();
    @(posedge clk_i);
    roll_o <= 1'b1;
    @(posedge clk_i);
    roll_o <= 1'b0;
  endtask

  task automatic fin();
    @(posedge clk_i);
    end_o <= 1'b1;
    @(posedge clk_i);
    end_o <= 1'b0;
  endtask
endmodule // mmf_bus_model

// ===== verif/mmf_msg_flags_asserts.sv
// Checker for the message flag block: record strobe, flag collection
// and APB decode. Sees only top module ports; bound at the file end.
`timescale 1ns/100ps

module mmf_msg_flags_asserts
  import mmf_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic resetn_i, // Reset, active low
  input wire logic word_valid_i, // Word strobe
  input wire mmf_role_t word_role_i, // Word role
  input wire logic word_bad_i, // Invalid word
  input wire logic rollover_i, // Buffer wrap pulse
  input wire logic msg_end_i, // Message end pulse
  input wire logic rec_valid_o, // Record strobe
  input wire logic [15:0] rec_word_o, // Record word
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic [11:0] paddr, // APB address
  input wire logic pready, // APB ready
  input wire logic pslverr // APB error
);
  logic in_r;
  logic roll_r;
  logic bad_r;
  wire logic first_w = word_valid_i && word_role_i == ROLE_CMD1;
  wire logic bad_w = word_valid_i && word_bad_i;
  wire logic map_w = paddr == 12'h000 || paddr == 12'h004;
  wire logic err_w = |{rec_word_o[9], rec_word_o[5:2]};

  // Shadow of the open message; a first command restarts it
  always_ff @(posedge clk_sys_i or negedge resetn_i)
    if (!resetn_i)
      {in_r, roll_r, bad_r} <= 3'h0;
    else if (first_w)
      {in_r, roll_r, bad_r} <= {1'b1, rollover_i, word_bad_i};
    else if (in_r)
      {in_r, roll_r, bad_r} <= {!msg_end_i, roll_r | rollover_i,
        bad_r | bad_w};

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_end;
    in_r && msg_end_i;
  endsequence
  sequence s_rec;
    rec_valid_o;
  endsequence

  a_rec_after_end:
    assert property (s_end |=> rec_valid_o)
    else $error("no record after message end");
  a_rec_cause:
    assert property (s_rec |-> $past(msg_end_i))
    else $error("record without message end");
  a_rec_holds:
    assert property (!rec_valid_o |-> $stable(rec_word_o))
    else $error("record word changed without strobe");
  a_good_inverse:
    assert property (s_rec |-> rec_word_o[8] ^ rec_word_o[12])
    else $error("good flag not inverse of summary");
  a_any_summary:
    assert property (s_rec ##0 err_w |-> rec_word_o[12])
    else $error("summary flag missing");
  a_roll_flag:
    assert property (s_rec |-> rec_word_o[7] == roll_r)
    else $error("rollover flag wrong");
  a_invalid_flag:
    assert property (s_rec |-> rec_word_o[3] == bad_r)
    else $error("invalid word flag wrong");
  a_unused_zero:
    assert property (s_rec |-> {rec_word_o[15:13], rec_word_o[11:10]} == 0)
    else $error("unused record bits set");
  a_apb_error:
    assert property (psel && penable |-> pslverr == !map_w)
    else $error("slave error decode wrong");
  a_apb_ready:
    assert property (psel |-> pready)
    else $error("ready low in transfer");
endmodule // mmf_msg_flags_asserts

bind mmf_msg_flags mmf_msg_flags_asserts u_chk (.clk_sys_i, .resetn_i,
  .word_valid_i, .word_role_i, .word_bad_i, .rollover_i, .msg_end_i,
  .rec_valid_o, .rec_word_o, .psel, .penable, .paddr, .pready, .pslverr);

// ===== verif/mmf_msg_flags_test.sv
// Bench for the message flag block: APB register access and one record
// check per message. Assumes the word stream model beside it.
`timescale 1ns/100ps

module mmf_msg_flags_test;
  localparam int LG = 420; // Dead time clear of the short-gap limit
  logic clk_sys_i, resetn_i, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic word_valid_i, word_cmd_sync_i, word_bad_i, sync_seen_i;
  logic resp_wait_i, rollover_i, msg_end_i, rec_valid_o;
  logic [15:0] word_data_i, rec_word_o;
  mmf_pkg::mmf_role_t word_role_i;
  int bad_count = 0;
  int tests_run = 0;

  // Default timeout limits, so the real response intervals are exercised
  mmf_msg_flags u_mmf_msg_flags (.clk_sys_i, .resetn_i, .word_valid_i,
    .word_data_i, .word_role_i, .word_cmd_sync_i, .word_bad_i, .sync_seen_i,
    .resp_wait_i, .rollover_i, .msg_end_i, .rec_valid_o, .rec_word_o,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  mmf_bus_model u_mmf_bus_model (.clk_i(clk_sys_i), .valid_o(word_valid_i),
    .data_o(word_data_i), .role_o(word_role_i), .csync_o(word_cmd_sync_i),
    .bad_o(word_bad_i), .sync_o(sync_seen_i), .wait_o(resp_wait_i),
    .roll_o(rollover_i), .end_o(msg_end_i));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_sys_i);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  task automatic c1(input logic [15:0] v);
    u_mmf_bus_model.w(mmf_pkg::ROLE_CMD1, v, 1'b1, 1'b0, LG);
  endtask
  task automatic dt(input logic cs);
    u_mmf_bus_model.w(mmf_pkg::ROLE_DATA, 16'hA5C3, cs, 1'b0, LG);
  endtask
  task automatic st(input logic [15:0] v, input logic bd, input int g);
    u_mmf_bus_model.w(mmf_pkg::ROLE_STAT, v, 1'b1, bd, g);
  endtask

  // End the message, wait a bounded time for the strobe, compare record
  task automatic close(input logic [15:0] e);
    u_mmf_bus_model.fin();
    repeat (3)
    begin
      @(negedge clk_sys_i);
      if (rec_valid_o === 1'b1)
        break;
    end
    chk({15'h0000, rec_valid_o, rec_word_o}, {16'h0001, e});
    $display("Test done: record %h", e);
  endtask

  // RT-to-RT: receive command to address 3, then the second command
  task automatic rr(input logic [15:0] c, input logic [15:0] s,
    input logic cs, input logic bd, input int g, input logic [15:0] e);
    c1(16'h1841);
    u_mmf_bus_model.w(mmf_pkg::ROLE_CMD2, c, cs, 1'b0, LG);
    st(s, bd, g);
    dt(1'b0);
    st(16'h1800, 1'b0, LG);
    close(e);
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, resetn_i} = 48'h0;
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_0000);
    c1(16'h1842);
    dt(1'b0);
    dt(1'b0);
    st(16'h1800, 1'b0, LG);
    close(16'h0100);
    c1(16'h1843);
    dt(1'b0);
    dt(1'b0);
    st(16'h1800, 1'b0, LG);
    close(16'h1020);
    c1(16'h1C44);
    st(16'h1808, 1'b0, LG);
    close(16'h0140);
    c1(16'h1841);
    dt(1'b1);
    st(16'h1800, 1'b0, LG);
    close(16'h1010);
    c1(16'h1841);
    dt(1'b0);
    u_mmf_bus_model.roll();
    st(16'h1800, 1'b1, LG);
    close(16'h1088);
    c1(16'hFC41);
    dt(1'b0);
    close(16'h1001);
    c1(16'h1805);
    st(16'h1800, 1'b0, LG);
    close(16'h0101);
    c1(16'hFFE2);
    close(16'h1001);
    rr(16'h2C41, 16'h2800, 1'b1, 1'b0, 100, 16'h0100);
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_D000);
    rr(16'h2C41, 16'h2800, 1'b1, 1'b0, 100, 16'h1004);
    rr(16'h2C41, 16'h2800, 1'b1, 1'b0, LG, 16'h0100);
    rr(16'h2841, 16'h2800, 1'b1, 1'b0, LG, 16'h1002);
    rr(16'h2C01, 16'h2800, 1'b1, 1'b0, LG, 16'h0102);
    rr(16'h1C41, 16'h1800, 1'b1, 1'b0, LG, 16'h0102);
    rr(16'h2C41, 16'h2800, 1'b0, 1'b0, LG, 16'h1012);
    rr(16'h2C41, 16'h3000, 1'b1, 1'b0, LG, 16'h1004);
    rr(16'h2C41, 16'h2800, 1'b1, 1'b1, LG, 16'h100C);
    // Status after the shorter limits but inside the selected one
    c1(16'h1C42);
    u_mmf_bus_model.wt(1'b1);
    st(16'h1800, 1'b0, 6000);
    u_mmf_bus_model.wt(1'b0);
    dt(1'b0);
    dt(1'b0);
    close(16'h0100);
    c1(16'h1C42);
    u_mmf_bus_model.wt(1'b1);
    repeat (13200) @(posedge clk_sys_i);
    u_mmf_bus_model.wt(1'b0);
    close(16'h1200);
    apb(1'b1, 12'h004, 32'h0000_FFFF);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_2400);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_0001);
    $display("Test done: registers");
    final_report();
  end

  // Watchdog well beyond the expected run of about 48k cycles
  initial
  begin
    #800000;
    bad_count++;
    final_report();
  end
endmodule // mmf_msg_flags_test
